/* pkg/tcrb_consts.svh */
`ifndef TCRB_CONSTS_SVH
`define TCRB_CONSTS_SVH

// register indices on both access ports
`define TCRB_IDX_FINAL_BLK    3'h0
`define TCRB_IDX_MIRROR_BLK   3'h1
`define TCRB_IDX_WDT_LOW      3'h2
`define TCRB_IDX_WDT_HIGH     3'h3
`define TCRB_IDX_STRETCH      3'h4
`define TCRB_IDX_LOCK         3'h5

// reset values
`define TCRB_RST_FINAL_BLK    8'h00
`define TCRB_RST_MIRROR_BLK   8'hF8
`define TCRB_RST_WDT_LOW      8'h48
`define TCRB_RST_WDT_HIGH     8'h08
`define TCRB_RST_STRETCH      1'h1
`define TCRB_RST_LOCK         2'h0

// field positions and codes
`define TCRB_BIT_STRETCH      0
`define TCRB_BIT_LOCK_RF      0
`define TCRB_BIT_LOCK_WIRED   1
`define TCRB_SEL_LAST_PAGE    2'h2

`endif

/* pkg/tcrb_pkg.sv */
package tcrb_pkg;

  // one register access request from either interface
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [2:0] idx;
    logic [7:0] wdata;
  } tcrb_req_t;

  // read answer, one cycle after the request
  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } tcrb_rsp_t;

  // contactless page read report
  typedef struct packed {
    logic       valid;
    logic [7:0] block;
    logic       last_page;
  } tcrb_page_t;

endpackage : tcrb_pkg

/* rtl/tcrb_bank.sv */
`timescale 1ns/1ps
`include "tcrb_consts.svh"

module tcrb_bank (
  input  logic                   clk_sys,
  input  logic                   rstn,
  input  tcrb_pkg::tcrb_req_t    rf_req,
  input  tcrb_pkg::tcrb_req_t    wired_req,
  output tcrb_pkg::tcrb_rsp_t    rf_rsp,
  output tcrb_pkg::tcrb_rsp_t    wired_rsp,
  input  tcrb_pkg::tcrb_page_t   rf_page_rd,
  input  logic                   message_flag_rd,
  input  logic [1:0]             event_deactivation_select,
  input  logic                   field_present,
  input  logic                   event_activate,
  output logic [7:0]             final_message_block_addr,
  output logic [7:0]             mirror_window_block_addr,
  output logic [15:0]            watchdog_time_active,
  output logic                   stretch_enable,
  output logic [1:0]             config_lock,
  output logic                   message_read_flag,
  output logic                   event_pin
);

  // side 0 is contactless, side 1 is wired; matches lock bit order
  tcrb_pkg::tcrb_req_t req [2];
  tcrb_pkg::tcrb_rsp_t rsp_r [2];

  logic [7:0]  final_blk_r;
  logic [7:0]  mirror_blk_r;
  logic [7:0]  wdt_low_r;
  logic [7:0]  wdt_high_r;
  logic [15:0] wdt_active_r;
  logic        stretch_r;
  logic [1:0]  lock_r;
  logic        msg_flag_r;
  logic        event_pin_r;
  logic        field_prev_r;

  logic [1:0]  wr_ok;
  logic [7:0]  final_blk_nxt;
  logic [7:0]  mirror_blk_nxt;
  logic [7:0]  wdt_low_nxt;
  logic [7:0]  wdt_high_nxt;
  logic [7:0]  stretch_byte_nxt;
  logic [7:0]  lock_byte_wr;
  logic        stretch_nxt;
  logic [1:0]  lock_nxt;
  logic        wdt_load;
  logic [15:0] wdt_active_nxt;
  logic        last_hit;
  logic        field_off;
  logic        event_release;
  logic        msg_flag_nxt;
  logic        event_pin_nxt;

  assign req[0] = rf_req;
  assign req[1] = wired_req;

  // true when an accepted write of this side targets register idx
  function automatic logic wr_hit(
    input tcrb_pkg::tcrb_req_t r,
    input logic                ok,
    input logic [2:0]          idx
  );
    wr_hit = ok && (r.idx == idx);
  endfunction : wr_hit

  // merge both sides into one register; contactless lands last on a tie
  function automatic logic [7:0] wr_merge(
    input logic [7:0]          cur,
    input logic [2:0]          idx,
    input tcrb_pkg::tcrb_req_t r0,
    input tcrb_pkg::tcrb_req_t r1,
    input logic [1:0]          ok
  );
    logic [7:0] v;
    v = cur;
    if (wr_hit(r1, ok[1], idx))
      v = r1.wdata;
    if (wr_hit(r0, ok[0], idx))
      v = r0.wdata;
    wr_merge = v;
  endfunction : wr_merge

  // read mux, reserved bits come back as zero
  function automatic logic [7:0] rd_mux(
    input logic [2:0] idx,
    input logic [7:0] fb,
    input logic [7:0] mb,
    input logic [7:0] wl,
    input logic [7:0] wh,
    input logic       st,
    input logic [1:0] lk
  );
    case (idx)
      `TCRB_IDX_FINAL_BLK:  rd_mux = fb;
      `TCRB_IDX_MIRROR_BLK: rd_mux = mb;
      `TCRB_IDX_WDT_LOW:    rd_mux = wl;
      `TCRB_IDX_WDT_HIGH:   rd_mux = wh;
      `TCRB_IDX_STRETCH:    rd_mux = {7'h00, st};
      `TCRB_IDX_LOCK:       rd_mux = {6'h00, lk};
      default:              rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  // a side whose own lock bit is set may write nothing, lock register
  // included; with both set every write is gone for good
  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1)
    begin : g_side
      assign wr_ok[s] = req[s].valid && req[s].write && !lock_r[s];

      // answer every read a cycle later; unmapped indices read zero
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
          rsp_r[s] <= '0;
        else
          rsp_r[s] <= '{valid: req[s].valid && !req[s].write,
                        rdata: rd_mux(req[s].idx, final_blk_r, mirror_blk_r,
                                      wdt_low_r, wdt_high_r, stretch_r,
                                      lock_r)};
      end
    end
  endgenerate

  // next values; a refused write falls through and leaves cur untouched
  assign final_blk_nxt    = wr_merge(final_blk_r, `TCRB_IDX_FINAL_BLK,
                                     req[0], req[1], wr_ok);
  assign mirror_blk_nxt   = wr_merge(mirror_blk_r, `TCRB_IDX_MIRROR_BLK,
                                     req[0], req[1], wr_ok);
  assign wdt_low_nxt      = wr_merge(wdt_low_r, `TCRB_IDX_WDT_LOW,
                                     req[0], req[1], wr_ok);
  assign wdt_high_nxt     = wr_merge(wdt_high_r, `TCRB_IDX_WDT_HIGH,
                                     req[0], req[1], wr_ok);
  assign stretch_byte_nxt = wr_merge({7'h00, stretch_r}, `TCRB_IDX_STRETCH,
                                     req[0], req[1], wr_ok);
  assign stretch_nxt      = stretch_byte_nxt[`TCRB_BIT_STRETCH];
  assign lock_byte_wr     = wr_merge(8'h00, `TCRB_IDX_LOCK,
                                     req[0], req[1], wr_ok);
  assign lock_nxt         = lock_r | lock_byte_wr[1:0];

  // timer sees a new value only when the high byte is written
  assign wdt_load       = wr_hit(req[0], wr_ok[0], `TCRB_IDX_WDT_HIGH) ||
                          wr_hit(req[1], wr_ok[1], `TCRB_IDX_WDT_HIGH);
  assign wdt_active_nxt = wdt_load ? {wdt_high_nxt, wdt_low_nxt}
                                   : wdt_active_r;

  // last page of the final message block read over the field
  assign last_hit = rf_page_rd.valid && rf_page_rd.last_page &&
                    (rf_page_rd.block == final_blk_r);
  // a set in the same cycle as the read-clear wins, so no event is lost
  assign msg_flag_nxt = last_hit ? 1'b1
                      : (message_flag_rd ? 1'b0 : msg_flag_r);

  // release on field loss, or on last page when select is 10b
  assign field_off     = field_prev_r && !field_present;
  assign event_release = field_off ||
                         (last_hit &&
                          event_deactivation_select == `TCRB_SEL_LAST_PAGE);
  assign event_pin_nxt = event_activate ? 1'b1
                       : (event_release ? 1'b0 : event_pin_r);

  // configuration storage
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      final_blk_r  <= `TCRB_RST_FINAL_BLK;
      mirror_blk_r <= `TCRB_RST_MIRROR_BLK;
      wdt_low_r    <= `TCRB_RST_WDT_LOW;
      wdt_high_r   <= `TCRB_RST_WDT_HIGH;
      stretch_r    <= `TCRB_RST_STRETCH;
      lock_r       <= `TCRB_RST_LOCK;
    end
    else
    begin
      final_blk_r  <= final_blk_nxt;
      mirror_blk_r <= mirror_blk_nxt;
      wdt_low_r    <= wdt_low_nxt;
      wdt_high_r   <= wdt_high_nxt;
      stretch_r    <= stretch_nxt;
      lock_r       <= lock_nxt;
    end
  end

  // timer value and event state
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wdt_active_r <= {`TCRB_RST_WDT_HIGH, `TCRB_RST_WDT_LOW};
      msg_flag_r   <= 1'b0;
      event_pin_r  <= 1'b0;
      field_prev_r <= 1'b0;
    end
    else
    begin
      wdt_active_r <= wdt_active_nxt;
      msg_flag_r   <= msg_flag_nxt;
      event_pin_r  <= event_pin_nxt;
      field_prev_r <= field_present;
    end
  end

  // outputs, all from flip-flops
  assign rf_rsp                   = rsp_r[0];
  assign wired_rsp                = rsp_r[1];
  assign final_message_block_addr = final_blk_r;
  assign mirror_window_block_addr = mirror_blk_r;
  assign watchdog_time_active     = wdt_active_r;
  assign stretch_enable           = stretch_r;
  assign config_lock              = lock_r;
  assign message_read_flag        = msg_flag_r;
  assign event_pin                = event_pin_r;

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence s_wired_final_wr;
    wired_req.valid && wired_req.write &&
    wired_req.idx == `TCRB_IDX_FINAL_BLK &&
    !(rf_req.valid && rf_req.write && rf_req.idx == `TCRB_IDX_FINAL_BLK);
  endsequence

  sequence s_low_only_wr;
    ((rf_req.valid && rf_req.write && rf_req.idx == `TCRB_IDX_WDT_LOW) ||
     (wired_req.valid && wired_req.write && wired_req.idx == `TCRB_IDX_WDT_LOW)) &&
    !(rf_req.valid && rf_req.write && rf_req.idx == `TCRB_IDX_WDT_HIGH) &&
    !(wired_req.valid && wired_req.write &&
      wired_req.idx == `TCRB_IDX_WDT_HIGH);
  endsequence

  // contactless requests aimed at one register
  sequence s_rf_final_wr;
    rf_req.valid && rf_req.write && rf_req.idx == `TCRB_IDX_FINAL_BLK;
  endsequence

  sequence s_rf_mirror_wr;
    rf_req.valid && rf_req.write && rf_req.idx == `TCRB_IDX_MIRROR_BLK &&
    !(wired_req.valid && wired_req.write && wired_req.idx == `TCRB_IDX_MIRROR_BLK);
  endsequence

  sequence s_rf_lock_wr;
    rf_req.valid && rf_req.write && rf_req.idx == `TCRB_IDX_LOCK &&
    !(wired_req.valid && wired_req.write && wired_req.idx == `TCRB_IDX_LOCK);
  endsequence

  sequence s_wired_lock_set;
    wired_req.valid && wired_req.write && wired_req.idx == `TCRB_IDX_LOCK &&
    wired_req.wdata[`TCRB_BIT_LOCK_WIRED];
  endsequence

  sequence s_last_page_sel;
    last_hit && event_deactivation_select == `TCRB_SEL_LAST_PAGE &&
    !event_activate;
  endsequence

  // a lock bit once set may only stay set
  a_lock_sticky: assert property (($past(lock_r) & ~lock_r) == 2'h0)
    else $error("lock bit returned to zero");

  a_wired_locked: assert property (lock_r[1] ##0 s_wired_final_wr
    |=> $stable(final_blk_r))
    else $error("wired write changed value while locked");

  a_rf_locked: assert property (lock_r[0] ##0 s_rf_mirror_wr
    |=> $stable(mirror_blk_r))
    else $error("contactless write changed value while locked");

  a_rf_lock_kept: assert property (lock_r[0] ##0 s_rf_lock_wr
    |=> $stable(lock_r))
    else $error("locked contactless side changed the lock register");

  a_wired_open: assert property (!lock_r[1] ##0 s_wired_final_wr
    |=> final_blk_r == $past(wired_req.wdata))
    else $error("allowed wired write not stored");

  // contactless wins a tie, so no wired term is needed here
  a_rf_open: assert property (!lock_r[0] ##0 s_rf_final_wr
    |=> final_blk_r == $past(rf_req.wdata))
    else $error("allowed contactless write not stored");

  a_lock_open: assert property (!lock_r[1] ##0 s_wired_lock_set
    |=> lock_r[`TCRB_BIT_LOCK_WIRED])
    else $error("unlocked wired side could not set its lock");

  a_final_hold: assert property (!(wr_ok[0] && rf_req.idx == `TCRB_IDX_FINAL_BLK) &&
    !(wr_ok[1] && wired_req.idx == `TCRB_IDX_FINAL_BLK) |=> $stable(final_blk_r))
    else $error("final block changed without an accepted write");

  // watchdog: load only on a high byte write, hold otherwise
  a_wdt_load: assert property (wdt_load
    |=> wdt_active_r == {wdt_high_r, wdt_low_r})
    else $error("watchdog value not loaded on high byte write");

  a_wdt_hold: assert property (!wdt_load |=> $stable(wdt_active_r))
    else $error("watchdog value changed without a high byte write");

  a_wdt_pending: assert property (s_low_only_wr ##0 !wdt_load
    |=> $stable(wdt_active_r))
    else $error("low byte write reached the timer early");

  // message flag: set by a hit, cleared by a read, held otherwise
  a_msg_set: assert property (last_hit
    |=> msg_flag_r ##1 (msg_flag_r || $past(message_flag_rd)))
    else $error("message read flag not set");

  a_msg_clear: assert property (message_flag_rd && !last_hit |=> !msg_flag_r)
    else $error("message read flag not cleared by read");

  a_msg_hold: assert property (!last_hit && !message_flag_rd
    |=> $stable(msg_flag_r))
    else $error("message read flag changed on its own");

  // event pin: activation wins, release on last page or field loss
  a_event_set: assert property (event_activate |=> event_pin_r)
    else $error("event pin not raised on activation");

  a_event_release: assert property (s_last_page_sel |=> !event_pin_r)
    else $error("event pin not released on last page");

  a_field_release: assert property (field_off && !event_activate
    |=> !event_pin_r)
    else $error("event pin not released on field loss");

  // reserved bits read back as zero
  a_rsv_zero: assert property (rf_req.valid && !rf_req.write &&
    rf_req.idx == `TCRB_IDX_LOCK |=> rf_rsp.valid && rf_rsp.rdata[7:2] == 6'h00)
    else $error("lock register reserved bits not zero");

  a_stretch_rsv: assert property (wired_req.valid && !wired_req.write &&
    wired_req.idx == `TCRB_IDX_STRETCH
    |=> wired_rsp.rdata == {7'h00, $past(stretch_enable)})
    else $error("stretch register readback wrong");

  a_both_locked: assert property (lock_r == 2'h3 |=> $stable(final_blk_r) &&
    $stable(mirror_blk_r) && $stable(wdt_high_r) && $stable(lock_r))
    else $error("write accepted with both locks set");

endmodule : tcrb_bank

/* sim/tcrb_far_model.sv */
`timescale 1ns/1ps

// stand-in for the contactless reader and the wired host
module tcrb_far_model (
  input  logic                 clk_sys,
  output tcrb_pkg::tcrb_req_t  rf_req,
  output tcrb_pkg::tcrb_req_t  wired_req,
  output tcrb_pkg::tcrb_page_t rf_page_rd
);
  // idle at time zero so the bank sees no request during reset
  initial
  begin
    rf_req     = '0;
    wired_req  = '0;
    rf_page_rd = '0;
  end

  // one access held for one edge; released data is inverted so stale bytes never match
  task automatic acc(input logic rf, input logic wr, input logic [2:0] idx,
                     input logic [7:0] d);
    tcrb_pkg::tcrb_req_t r;
    r = '{valid: 1'b1, write: wr, idx: idx, wdata: d};
    @(posedge clk_sys);
    if (rf)
      rf_req <= r;
    else
      wired_req <= r;
    r = '{valid: 1'b0, write: 1'b0, idx: idx, wdata: ~d};
    @(posedge clk_sys);
    if (rf)
      rf_req <= r;
    else
      wired_req <= r;
  endtask : acc

  // one page read report, pulsed for a single edge
  task automatic page(input logic [7:0] blk, input logic last);
    @(posedge clk_sys);
    rf_page_rd <= '{valid: 1'b1, block: blk, last_page: last};
    @(posedge clk_sys);
    rf_page_rd <= '{valid: 1'b0, block: ~blk, last_page: ~last};
  endtask : page
endmodule : tcrb_far_model

/* sim/tag_config_register_bank_tb.sv */
`timescale 1ns/1ps

module tag_config_register_bank_tb;
  typedef struct packed {
    logic       rf;
    logic       wr;
    logic [2:0] idx;
    logic [7:0] d;
    logic [7:0] exp;
  } tcrb_row_t;

  logic                 clk_sys, rstn, message_flag_rd, field_present, event_activate;
  logic [1:0]           event_deactivation_select, config_lock;
  tcrb_pkg::tcrb_req_t  rf_req, wired_req;
  tcrb_pkg::tcrb_rsp_t  rf_rsp, wired_rsp;
  tcrb_pkg::tcrb_page_t rf_page_rd;
  logic [7:0]           final_message_block_addr, mirror_window_block_addr;
  logic [15:0]          watchdog_time_active;
  logic                 stretch_enable, message_read_flag, event_pin;
  int                   fails, comparisons;
  // reset reads first, then write and read back; block ranges kept legal
  tcrb_row_t            rows [0:12] = '{
    '{0, 0, 3'h0, 8'h00, 8'h00}, '{0, 0, 3'h1, 8'h00, 8'hF8}, '{1, 0, 3'h2, 8'h00, 8'h48},
    '{1, 0, 3'h3, 8'h00, 8'h08}, '{0, 0, 3'h4, 8'h00, 8'h01}, '{1, 0, 3'h5, 8'h00, 8'h00},
    '{0, 1, 3'h0, 8'h37, 8'h37}, '{1, 1, 3'h0, 8'h7F, 8'h7F}, '{0, 1, 3'h1, 8'h34, 8'h34},
    '{1, 1, 3'h1, 8'h7C, 8'h7C}, '{0, 1, 3'h4, 8'hFE, 8'h00}, '{0, 1, 3'h6, 8'h55, 8'h00},
    '{1, 1, 3'h0, 8'h05, 8'h05}};

  tcrb_far_model u_tcrb_far_model (.clk_sys, .rf_req, .wired_req, .rf_page_rd);

  tcrb_bank u_tcrb_bank (.clk_sys, .rstn, .rf_req, .wired_req, .rf_rsp, .wired_rsp,
    .rf_page_rd, .message_flag_rd, .event_deactivation_select, .field_present,
    .event_activate, .final_message_block_addr, .mirror_window_block_addr,
    .watchdog_time_active, .stretch_enable, .config_lock, .message_read_flag, .event_pin);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // a write lands at the edge that ends the request
  task automatic wr(input logic rf, input logic [2:0] idx, input logic [7:0] d);
    u_tcrb_far_model.acc(rf, 1'b1, idx, d);
    #1;
  endtask : wr

  // the answer stands one cycle only, so it is sampled right after that edge
  task automatic rd(input logic rf, input logic [2:0] idx, input logic [7:0] exp);
    u_tcrb_far_model.acc(rf, 1'b0, idx, 8'h00);
    #1;
    check(rf ? rf_rsp : wired_rsp, {1'b1, exp});
  endtask : rd

  task automatic pulse_event;
    @(posedge clk_sys);
    event_activate <= 1'b1;
    @(posedge clk_sys);
    event_activate <= 1'b0;
    #1;
  endtask : pulse_event

  // one read of the message flag as seen by the bank
  task automatic pulse_flag_rd;
    @(posedge clk_sys);
    message_flag_rd <= 1'b1;
    @(posedge clk_sys);
    message_flag_rd <= 1'b0;
    #1;
  endtask : pulse_flag_rd

  task automatic finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // free running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // the whole run needs about 125 cycles; a hang is cut well after that
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    finish_test();
  end

  initial
  begin
    fails = 0;
    comparisons = 0;
    rstn = 1'b0;
    message_flag_rd = 1'b0;
    field_present = 1'b1;
    event_activate = 1'b0;
    event_deactivation_select = 2'h2;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    #1;
    check(watchdog_time_active, 16'h0848);
    check({config_lock, stretch_enable, message_read_flag, event_pin}, 16'h0004);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr(rows[i].rf, rows[i].idx, rows[i].d);
      rd(rows[i].rf, rows[i].idx, rows[i].exp);
    end
    check({final_message_block_addr, mirror_window_block_addr}, 16'h057C);
    check(stretch_enable, 1'b0);
    wr(1'b1, 3'h4, 8'h01);
    check(stretch_enable, 1'b1);
    // low byte waits for the high byte
    wr(1'b0, 3'h2, 8'h12);
    check(watchdog_time_active, 16'h0848);
    rd(1'b1, 3'h2, 8'h12);
    wr(1'b1, 3'h3, 8'h34);
    check(watchdog_time_active, 16'h3412);
    // misses on block or page leave the flag alone; the hit sets it and drops the pin
    pulse_event();
    check(event_pin, 1'b1);
    u_tcrb_far_model.page(8'h05, 1'b0);
    u_tcrb_far_model.page(8'h04, 1'b1);
    #1;
    check(message_read_flag, 1'b0);
    u_tcrb_far_model.page(8'h05, 1'b1);
    #1;
    check({message_read_flag, event_pin}, 2'h2);
    pulse_flag_rd();
    check(message_read_flag, 1'b0);
    // other select codes keep the pin through a hit, field loss still drops it
    @(posedge clk_sys);
    event_deactivation_select <= 2'h1;
    pulse_event();
    u_tcrb_far_model.page(8'h05, 1'b1);
    #1;
    check({message_read_flag, event_pin}, 2'h3);
    @(posedge clk_sys);
    field_present <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check(event_pin, 1'b0);
    // a hit in the same cycle as the flag read keeps the flag set
    pulse_flag_rd();
    check(message_read_flag, 1'b0);
    fork
      u_tcrb_far_model.page(8'h05, 1'b1);
      pulse_flag_rd();
    join
    check(message_read_flag, 1'b1);
    // both sides write one register in one cycle, contactless lands
    fork
      wr(1'b1, 3'h0, 8'hA1);
      wr(1'b0, 3'h0, 8'hB2);
    join
    check(final_message_block_addr, 8'hA1);
    // lock one side, then both
    wr(1'b1, 3'h5, 8'h01);
    check(config_lock, 2'h1);
    wr(1'b1, 3'h0, 8'h22);
    rd(1'b0, 3'h0, 8'hA1);
    wr(1'b1, 3'h1, 8'h33);
    rd(1'b1, 3'h1, 8'h7C);
    wr(1'b0, 3'h0, 8'h22);
    rd(1'b1, 3'h0, 8'h22);
    wr(1'b1, 3'h5, 8'h02);
    check(config_lock, 2'h1);
    wr(1'b0, 3'h5, 8'h00);
    check(config_lock, 2'h1);
    wr(1'b0, 3'h5, 8'hFE);
    rd(1'b1, 3'h5, 8'h03);
    wr(1'b0, 3'h1, 8'h11);
    rd(1'b0, 3'h1, 8'h7C);
    wr(1'b0, 3'h0, 8'h44);
    rd(1'b1, 3'h0, 8'h22);
    wr(1'b0, 3'h5, 8'h00);
    check(config_lock, 2'h3);
    finish_test();
  end
endmodule : tag_config_register_bank_tb
